// File: src/alarm_channel.sv
// One alarm channel: static level or dynamic rate-of-change compare.
// Assumes tick marks a fresh output sample on value.
`timescale 1ns/10ps
module alarm_channel import bias_alarm_pkg::*; #(
  parameter int DEPTH = 256
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Sample stream
  input wire logic tick,
  input wire logic signed [15:0] value,
  // Configuration
  input wire logic src_on,
  input wire logic dynamic,
  input wire logic above,
  input wire logic signed [15:0] threshold,
  input wire logic [CNT_W-1:0] count,
  // Result
  output logic alarm
);
  localparam int AW = $clog2(DEPTH);

  logic signed [15:0] hist_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d;
  logic [CNT_W-1:0] fill_q, fill_d;
  logic alarm_q, alarm_d;
  logic [CNT_W-1:0] span;
  logic signed [15:0] ref_val;
  logic signed [16:0] delta, mag, thr_mag;
  logic static_hit, dyn_hit;

  always_comb begin
    span = (count == '0) ? CNT_W'(1) : count;
    ref_val = hist_q[AW'(wp_q - AW'(span))];
    delta = 17'(value) - 17'(ref_val);
    mag = delta[16] ? -delta : delta;
    thr_mag = threshold[15] ? -17'(threshold) : 17'(threshold);
    static_hit = above ? (value > threshold) : (value < threshold);
    dyn_hit = (fill_q >= span) && (above ? (mag > thr_mag) : (mag < thr_mag));
    wp_d = wp_q;
    fill_d = fill_q;
    alarm_d = alarm_q;
    if (!src_on) begin
      fill_d = '0;
      alarm_d = 1'b0;
    end else if (tick) begin
      wp_d = AW'(wp_q + AW'(1));
      if (fill_q != '1) fill_d = CNT_W'(fill_q + CNT_W'(1));
      alarm_d = dynamic ? dyn_hit : static_hit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wp_q <= '0;
      fill_q <= '0;
      alarm_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      fill_q <= fill_d;
      alarm_q <= alarm_d;
    end
  end

  // Sample history, not reset
  always_ff @(posedge clk_sys) begin
    if (tick) hist_q[wp_q] <= value;
  end

  assign alarm = alarm_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  AST_STATIC_CMP: assert property (src_on && tick && !dynamic |=>
    alarm == $past(static_hit))
    else $error("static alarm result wrong");
  AST_OFF_CLEARS: assert property (!src_on |=> !alarm)
    else $error("disabled alarm still active");
  AST_PER_SAMPLE: assert property ($changed(alarm) |-> $past(tick) || !$past(src_on))
    else $error("alarm changed without a sample");
  AST_DYN_WAIT: assert property (src_on && tick && dynamic && fill_q == '0 && count > 8'h01
                                 |=> !alarm)
    else $error("dynamic alarm fired before history filled");

endmodule // alarm_channel

// File: src/bias_alarm_pkg.sv
// Constants, field positions and carrier types for bias trim and alarms.
// Assumes a 16-bit register port decoded by byte address upstream.
package bias_alarm_pkg;

  // Register byte addresses
  localparam logic [6:0] OFF_GYRO_X_TRIM = 7'h1a;
  localparam logic [6:0] OFF_GYRO_Y_TRIM = 7'h1c;
  localparam logic [6:0] OFF_GYRO_Z_TRIM = 7'h1e;
  localparam logic [6:0] OFF_ACCEL_X_TRIM = 7'h20;
  localparam logic [6:0] OFF_ACCEL_Y_TRIM = 7'h22;
  localparam logic [6:0] OFF_ACCEL_Z_TRIM = 7'h24;
  localparam logic [6:0] OFF_MISC_CTRL = 7'h34;
  localparam logic [6:0] OFF_GLOBAL_CMD = 7'h3e;
  localparam logic [6:0] OFF_ALM1_THRESH = 7'h40;
  localparam logic [6:0] OFF_ALM2_THRESH = 7'h42;
  localparam logic [6:0] OFF_ALM1_COUNT = 7'h44;
  localparam logic [6:0] OFF_ALM2_COUNT = 7'h46;
  localparam logic [6:0] OFF_ALARM_CTRL = 7'h48;

  // Reset values
  localparam logic [15:0] RST_TRIM = 16'h0000;
  localparam logic [15:0] RST_CTRL = 16'h0000;

  // Field positions
  localparam int CMD_AUTONULL_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int MISC_POP_BIT = 6;
  localparam int ACC_YZ_W = 14;
  localparam int CNT_W = 8;
  localparam int SRC2_LSB = 12;
  localparam int SRC1_LSB = 8;
  localparam int SRC_W = 4;
  localparam int DYN2_BIT = 7;
  localparam int DYN1_BIT = 6;
  localparam int POL2_BIT = 5;
  localparam int POL1_BIT = 4;
  localparam int FILT_BIT = 3;
  localparam int IND_EN_BIT = 2;
  localparam int IND_POL_BIT = 1;
  localparam int IND_SEL_BIT = 0;

  // Source selection codes
  localparam logic [3:0] SRC_OFF = 4'h0;
  localparam logic [3:0] SRC_GX = 4'h1;
  localparam logic [3:0] SRC_GY = 4'h2;
  localparam logic [3:0] SRC_GZ = 4'h3;
  localparam logic [3:0] SRC_AX = 4'h4;
  localparam logic [3:0] SRC_AY = 4'h5;
  localparam logic [3:0] SRC_AZ = 4'h6;
  localparam logic [3:0] SRC_TEMP = 4'hc;

  typedef struct packed {
    logic signed [15:0] gx;
    logic signed [15:0] gy;
    logic signed [15:0] gz;
    logic signed [15:0] ax;
    logic signed [15:0] ay;
    logic signed [15:0] az;
    logic signed [15:0] temp;
  } sample_set_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef enum logic [2:0] {
    AN_IDLE = 3'b001,
    AN_FLASH_REQ = 3'b010,
    AN_FLASH_WAIT = 3'b100
  } autonull_state_t;

  // Saturating 16-bit signed add
  function automatic logic signed [15:0] sat_add(input logic signed [15:0] a,
                                                 input logic signed [15:0] b);
    logic signed [16:0] s;
    s = 17'(a) + 17'(b);
    if (s > 17'sd32767) return 16'sh7fff;
    if (s < -17'sd32768) return 16'sh8000;
    return s[15:0];
  endfunction

  // Saturating negation
  function automatic logic signed [15:0] sat_neg(input logic signed [15:0] a);
    if (a == 16'sh8000) return 16'sh7fff;
    return -a;
  endfunction

endpackage

// File: src/bias_trim_alarms.sv
// Bias trim on sensor samples, automatic gyro null with flash backup,
// two alarms and their indicator on the digital lines.
// Assumes SPI framing, sampling, filtering and flash are outside.
//
// What this block does
// - Add gyro trim just before output register
// - Gyro trim 16-bit signed, resets zero
// - Command bit 0 loads negated gyro outputs
// - Backup to flash automatically after null
// - Accel trims applied like gyro trims
// - Accel X 16-bit, Y Z 14-bit trims
// - Misc bit 6 enables percussion translation
// - Two independent alarms, own settings each except one shared filter select bit
// - Static mode compares source against threshold
// - Threshold uses selected source's format
// - Dynamic mode compares change over samples
// - Sample count 8-bit, 0 and 1 mean one
// - Source field selects axis, temperature, or off
// - Control bits select dynamic, polarity, filtering
// - Indicator enable, level, line select bits
`timescale 1ns/10ps
module bias_trim_alarms import bias_alarm_pkg::*; #(
  parameter int HIST_DEPTH = 256
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  // Sensor samples
  input wire logic sample_valid,
  input wire sample_set_t raw_sample,
  input wire sample_set_t filt_sample,
  // Output registers
  output sample_set_t out_sample,
  output logic out_valid,
  // Flash backup handshake
  output logic flash_req,
  input wire logic flash_done,
  output logic autonull_busy,
  // Point of percussion enable
  output logic pop_enable,
  // Alarm results and digital lines
  output logic [1:0] alarm_active,
  output logic line1_out,
  output logic line1_oe,
  output logic line2_out,
  output logic line2_oe
);

  logic signed [15:0] gx_trim_q, gx_trim_d, gy_trim_q, gy_trim_d, gz_trim_q, gz_trim_d;
  logic signed [15:0] ax_trim_q, ax_trim_d;
  logic signed [ACC_YZ_W-1:0] ay_trim_q, ay_trim_d, az_trim_q, az_trim_d;
  logic [15:0] misc_q, misc_d, alarm_control_q, alarm_control_d;
  logic signed [15:0] thr1_q, thr1_d, thr2_q, thr2_d;
  logic [CNT_W-1:0] cnt1_q, cnt1_d, cnt2_q, cnt2_d;
  logic [15:0] rdata_q, rdata_d;
  sample_set_t out_q, out_d, filt_q, filt_d;
  logic valid_q, valid_d;
  autonull_state_t an_q, an_d;
  logic autonull_go;
  logic [SRC_W-1:0] src1, src2;
  logic signed [15:0] val1, val2;
  logic ind_level;

  function automatic logic signed [15:0] pick(input sample_set_t s, input logic [3:0] sel);
    unique case (sel)
      SRC_GX: return s.gx;
      SRC_GY: return s.gy;
      SRC_GZ: return s.gz;
      SRC_AX: return s.ax;
      SRC_AY: return s.ay;
      SRC_AZ: return s.az;
      SRC_TEMP: return s.temp;
      default: return 16'sh0000;
    endcase
  endfunction

  function automatic sample_set_t trim_set(input sample_set_t s, input logic signed [15:0] gx,
                                           input logic signed [15:0] gy,
                                           input logic signed [15:0] gz,
                                           input logic signed [15:0] ax,
                                           input logic signed [15:0] ay,
                                           input logic signed [15:0] az);
    sample_set_t r;
    r.gx = sat_add(s.gx, gx);
    r.gy = sat_add(s.gy, gy);
    r.gz = sat_add(s.gz, gz);
    r.ax = sat_add(s.ax, ax);
    r.ay = sat_add(s.ay, ay);
    r.az = sat_add(s.az, az);
    r.temp = s.temp;
    return r;
  endfunction

  assign autonull_go = reg_req.wr && reg_req.addr == OFF_GLOBAL_CMD
                       && reg_req.wdata[CMD_AUTONULL_BIT] && an_q == AN_IDLE;

  // Register writes and autonull capture
  always_comb begin
    gx_trim_d = gx_trim_q;
    gy_trim_d = gy_trim_q;
    gz_trim_d = gz_trim_q;
    ax_trim_d = ax_trim_q;
    ay_trim_d = ay_trim_q;
    az_trim_d = az_trim_q;
    misc_d = misc_q;
    alarm_control_d = alarm_control_q;
    thr1_d = thr1_q;
    thr2_d = thr2_q;
    cnt1_d = cnt1_q;
    cnt2_d = cnt2_q;
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        OFF_GYRO_X_TRIM: gx_trim_d = reg_req.wdata;
        OFF_GYRO_Y_TRIM: gy_trim_d = reg_req.wdata;
        OFF_GYRO_Z_TRIM: gz_trim_d = reg_req.wdata;
        OFF_ACCEL_X_TRIM: ax_trim_d = reg_req.wdata;
        OFF_ACCEL_Y_TRIM: ay_trim_d = reg_req.wdata[ACC_YZ_W-1:0];
        OFF_ACCEL_Z_TRIM: az_trim_d = reg_req.wdata[ACC_YZ_W-1:0];
        OFF_MISC_CTRL: misc_d = reg_req.wdata;
        OFF_ALARM_CTRL: alarm_control_d = reg_req.wdata;
        OFF_ALM1_THRESH: thr1_d = reg_req.wdata;
        OFF_ALM2_THRESH: thr2_d = reg_req.wdata;
        OFF_ALM1_COUNT: cnt1_d = reg_req.wdata[CNT_W-1:0];
        OFF_ALM2_COUNT: cnt2_d = reg_req.wdata[CNT_W-1:0];
        default: ;
      endcase
    end
    if (autonull_go) begin
      gx_trim_d = sat_neg(out_q.gx);
      gy_trim_d = sat_neg(out_q.gy);
      gz_trim_d = sat_neg(out_q.gz);
    end
  end

  // Read data, registered one cycle after the read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        OFF_GYRO_X_TRIM: rdata_d = gx_trim_q;
        OFF_GYRO_Y_TRIM: rdata_d = gy_trim_q;
        OFF_GYRO_Z_TRIM: rdata_d = gz_trim_q;
        OFF_ACCEL_X_TRIM: rdata_d = ax_trim_q;
        OFF_ACCEL_Y_TRIM: rdata_d = {2'b00, ay_trim_q};
        OFF_ACCEL_Z_TRIM: rdata_d = {2'b00, az_trim_q};
        OFF_MISC_CTRL: rdata_d = misc_q;
        OFF_GLOBAL_CMD: rdata_d = {15'h0000, an_q != AN_IDLE};
        OFF_ALARM_CTRL: rdata_d = alarm_control_q;
        OFF_ALM1_THRESH: rdata_d = thr1_q;
        OFF_ALM2_THRESH: rdata_d = thr2_q;
        OFF_ALM1_COUNT: rdata_d = {8'h00, cnt1_q};
        OFF_ALM2_COUNT: rdata_d = {8'h00, cnt2_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // Output registers with trims
  always_comb begin
    out_d = out_q;
    filt_d = filt_q;
    valid_d = sample_valid;
    if (sample_valid) begin
      out_d = trim_set(raw_sample, gx_trim_q, gy_trim_q, gz_trim_q, ax_trim_q,
                       16'(ay_trim_q), 16'(az_trim_q));
      filt_d = trim_set(filt_sample, gx_trim_q, gy_trim_q, gz_trim_q, ax_trim_q,
                        16'(ay_trim_q), 16'(az_trim_q));
    end
  end

  // Autonull then flash backup
  always_comb begin
    an_d = an_q;
    unique case (an_q)
      AN_IDLE: if (autonull_go) an_d = AN_FLASH_REQ;
      AN_FLASH_REQ: an_d = AN_FLASH_WAIT;
      AN_FLASH_WAIT: if (flash_done) an_d = AN_IDLE;
      default: an_d = AN_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gx_trim_q <= RST_TRIM;
      gy_trim_q <= RST_TRIM;
      gz_trim_q <= RST_TRIM;
      ax_trim_q <= RST_TRIM;
      ay_trim_q <= RST_TRIM[ACC_YZ_W-1:0];
      az_trim_q <= RST_TRIM[ACC_YZ_W-1:0];
      misc_q <= RST_CTRL;
      alarm_control_q <= RST_CTRL;
      thr1_q <= RST_CTRL;
      thr2_q <= RST_CTRL;
      cnt1_q <= RST_CTRL[CNT_W-1:0];
      cnt2_q <= RST_CTRL[CNT_W-1:0];
      rdata_q <= 16'h0000;
      out_q <= '0;
      filt_q <= '0;
      valid_q <= 1'b0;
      an_q <= AN_IDLE;
    end else begin
      gx_trim_q <= gx_trim_d;
      gy_trim_q <= gy_trim_d;
      gz_trim_q <= gz_trim_d;
      ax_trim_q <= ax_trim_d;
      ay_trim_q <= ay_trim_d;
      az_trim_q <= az_trim_d;
      misc_q <= misc_d;
      alarm_control_q <= alarm_control_d;
      thr1_q <= thr1_d;
      thr2_q <= thr2_d;
      cnt1_q <= cnt1_d;
      cnt2_q <= cnt2_d;
      rdata_q <= rdata_d;
      out_q <= out_d;
      filt_q <= filt_d;
      valid_q <= valid_d;
      an_q <= an_d;
    end
  end

  // Alarm sources
  assign src1 = alarm_control_q[SRC1_LSB +: SRC_W];
  assign src2 = alarm_control_q[SRC2_LSB +: SRC_W];
  assign val1 = pick(alarm_control_q[FILT_BIT] ? filt_q : out_q, src1);
  assign val2 = pick(alarm_control_q[FILT_BIT] ? filt_q : out_q, src2);

  alarm_channel #(.DEPTH(HIST_DEPTH)) u_alarm1 (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(valid_q),
    .value(val1),
    .src_on(src1 != SRC_OFF),
    .dynamic(alarm_control_q[DYN1_BIT]),
    .above(alarm_control_q[POL1_BIT]),
    .threshold(thr1_q),
    .count(cnt1_q),
    .alarm(alarm_active[0])
  );

  alarm_channel #(.DEPTH(HIST_DEPTH)) u_alarm2 (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(valid_q),
    .value(val2),
    .src_on(src2 != SRC_OFF),
    .dynamic(alarm_control_q[DYN2_BIT]),
    .above(alarm_control_q[POL2_BIT]),
    .threshold(thr2_q),
    .count(cnt2_q),
    .alarm(alarm_active[1])
  );

  // Indicator routing; first line left alone while translation is on
  assign ind_level = (|alarm_active) ? alarm_control_q[IND_POL_BIT] : !alarm_control_q[IND_POL_BIT];
  assign line1_oe = alarm_control_q[IND_EN_BIT] && !alarm_control_q[IND_SEL_BIT]
                    && !misc_q[MISC_POP_BIT];
  assign line2_oe = alarm_control_q[IND_EN_BIT] && alarm_control_q[IND_SEL_BIT];
  assign line1_out = line1_oe && ind_level;
  assign line2_out = line2_oe && ind_level;

  assign pop_enable = misc_q[MISC_POP_BIT];
  assign reg_rdata = rdata_q;
  assign out_sample = out_q;
  assign out_valid = valid_q;
  assign flash_req = (an_q == AN_FLASH_REQ);
  assign autonull_busy = (an_q != AN_IDLE);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_autonull_cmd;
    autonull_go;
  endsequence
  sequence s_backup;
    flash_req ##1 (autonull_busy && !flash_req);
  endsequence

  AST_TRIM_ADD: assert property (sample_valid |=>
    out_sample.gx == sat_add($past(raw_sample.gx), $past(gx_trim_q)))
    else $error("gyro trim not applied");
  // Watched through reset itself, so no disable here
  AST_TRIM_RESET: assert property (disable iff (1'b0) sys_rst |=> gx_trim_q == RST_TRIM
    && gy_trim_q == RST_TRIM && gz_trim_q == RST_TRIM)
    else $error("gyro trim not zero after reset");
  AST_AUTONULL: assert property (s_autonull_cmd |=> gz_trim_q == sat_neg($past(out_q.gz)))
    else $error("autonull did not load negated output");
  AST_BACKUP: assert property (s_autonull_cmd |=> s_backup)
    else $error("flash backup not requested after autonull");
  AST_ACC_ZERO_TOP: assert property (reg_req.rd && reg_req.addr == OFF_ACCEL_Z_TRIM |=>
    reg_rdata[15:14] == 2'b00)
    else $error("unused accel trim bits not zero");
  AST_SATURATE: assert property (sample_valid && raw_sample.ax > 0 && ax_trim_q > 0 |=>
    out_sample.ax > 0)
    else $error("trim sum wrapped");
  AST_POP_LINE1: assert property (pop_enable |-> !line1_oe)
    else $error("first line driven during translation");
  AST_INDICATOR: assert property (alarm_control_q[IND_EN_BIT] && alarm_control_q[IND_SEL_BIT]
                                  && |alarm_active |-> line2_oe
                                  && line2_out == alarm_control_q[IND_POL_BIT])
    else $error("indicator level wrong");

endmodule // bias_trim_alarms

// File: test/bias_trim_alarms_tb.sv
// Self-checking bench for bias trim, automatic null and alarms.
// Assumes the flash partner answers every backup request.
`timescale 1ns/10ps
module bias_trim_alarms_tb;
  import bias_alarm_pkg::*;

  localparam int LIMIT = 3000;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_t reg_req = '0;
  logic [15:0] reg_rdata;
  logic sample_valid = 1'b0;
  sample_set_t raw_sample = '0;
  sample_set_t filt_sample = '0;
  sample_set_t out_sample;
  logic out_valid, flash_req, flash_done, autonull_busy, pop_enable;
  logic [1:0] alarm_active;
  logic line1_out, line1_oe, line2_out, line2_oe;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [6:0] map_addr [11] = '{7'h1a, 7'h1c, 7'h1e, 7'h20, 7'h22, 7'h24,
                                7'h40, 7'h42, 7'h44, 7'h46, 7'h48};

  always #50 clk_sys = ~clk_sys;

  bias_trim_alarms i_bias_trim_alarms (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .raw_sample(raw_sample), .filt_sample(filt_sample),
    .out_sample(out_sample), .out_valid(out_valid), .flash_req(flash_req),
    .flash_done(flash_done), .autonull_busy(autonull_busy), .pop_enable(pop_enable),
    .alarm_active(alarm_active), .line1_out(line1_out), .line1_oe(line1_oe),
    .line2_out(line2_out), .line2_oe(line2_oe)
  );

  flash_partner i_flash_partner (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .flash_req(flash_req), .flash_done(flash_done)
  );

  task automatic report_and_stop();
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  // Each access lets one edge pass first, so strobes never fall and rise at once
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    #1;
    reg_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    #1;
    reg_req.rd = 1'b0;
    chk16("reg_rdata", exp, reg_rdata);
  endtask

  // One sample, filtered gx negated, then one more edge so the alarms have updated
  task automatic smp(input logic [15:0] gx, gy, gz, ax, ay, az);
    raw_sample = '{gx: gx, gy: gy, gz: gz, ax: ax, ay: ay, az: az, temp: 16'h0123};
    filt_sample = '{gx: 16'h0000 - gx, gy: gy, gz: gz, ax: ax, ay: ay, az: az, temp: 16'h0123};
    sample_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    sample_valid = 1'b0;
    chk_bit("out_valid", 1'b1, out_valid);
    @(posedge clk_sys);
    #1;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    @(posedge clk_sys);
    #1;
    foreach (map_addr[i]) rd(map_addr[i], 16'h0000);
    rd(7'h02, 16'h0000);
    // Trims, with 14-bit accel Y and 8-bit count fields
    wr(OFF_GYRO_X_TRIM, 16'hfff6);
    wr(OFF_GYRO_Z_TRIM, 16'h8000);
    wr(OFF_ACCEL_X_TRIM, 16'h0005);
    wr(OFF_ACCEL_Y_TRIM, 16'hffff);
    rd(OFF_ACCEL_Y_TRIM, 16'h3fff);
    wr(OFF_ALM1_COUNT, 16'h1234);
    rd(OFF_ALM1_COUNT, 16'h0034);
    rd(OFF_GYRO_X_TRIM, 16'hfff6);
    smp(16'd100, 16'hfffb, 16'hff9c, 16'h7ffe, 16'd100, 16'd7);
    chk16("out gx", 16'd90, out_sample.gx);
    chk16("out gy", 16'hfffb, out_sample.gy);
    chk16("out gz", 16'h8000, out_sample.gz);
    chk16("out ax", 16'h7fff, out_sample.ax);
    chk16("out ay", 16'd99, out_sample.ay);
    chk16("out az", 16'd7, out_sample.az);
    chk16("out temp", 16'h0123, out_sample.temp);
    // Automatic null on a steady sample, then backup without further command
    smp(16'd100, 16'hfffb, 16'hff9c, 16'h7ffe, 16'd100, 16'd7);
    wr(OFF_GLOBAL_CMD, 16'h0001);
    chk_bit("flash_req", 1'b1, flash_req);
    chk_bit("autonull_busy", 1'b1, autonull_busy);
    for (int i = 0; i < 40 && autonull_busy !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk_bit("autonull_busy", 1'b0, autonull_busy);
    rd(OFF_GYRO_X_TRIM, 16'hffa6);
    rd(OFF_GYRO_Y_TRIM, 16'h0005);
    rd(OFF_GYRO_Z_TRIM, 16'h7fff);
    wr(OFF_MISC_CTRL, 16'h0040);
    chk_bit("pop_enable", 1'b1, pop_enable);
    wr(OFF_MISC_CTRL, 16'h0000);
    // Static alarms: 1 above on gyro X, 2 below on accel Z, indicator on line 2
    wr(OFF_ALM1_THRESH, 16'd50);
    wr(OFF_ALARM_CTRL, 16'h6117);
    smp(16'd150, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hfffb);
    chk16("out gx", 16'd60, out_sample.gx);
    chk16("alarm_active", 16'h0003, {14'h0000, alarm_active});
    chk_bit("line2_oe", 1'b1, line2_oe);
    chk_bit("line2_out", 1'b1, line2_out);
    chk_bit("line1_oe", 1'b0, line1_oe);
    smp(16'd130, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0005);
    chk16("alarm_active", 16'h0000, {14'h0000, alarm_active});
    chk_bit("line2_out", 1'b0, line2_out);
    // Filtered source, indicator on line 1, then translation takes line 1
    wr(OFF_ALARM_CTRL, 16'h611e);
    smp(16'd150, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hfffb);
    chk16("alarm_active", 16'h0002, {14'h0000, alarm_active});
    chk_bit("line1_oe", 1'b1, line1_oe);
    chk_bit("line1_out", 1'b1, line1_out);
    chk_bit("line2_oe", 1'b0, line2_oe);
    wr(OFF_MISC_CTRL, 16'h0040);
    chk_bit("line1_oe", 1'b0, line1_oe);
    wr(OFF_MISC_CTRL, 16'h0000);
    // Dynamic alarm 1 over two samples, alarm 2 off
    wr(OFF_ALM1_COUNT, 16'h0002);
    wr(OFF_ALM1_THRESH, 16'd20);
    wr(OFF_ALARM_CTRL, 16'h0150);
    repeat (4) smp(16'd90, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hfffb);
    chk16("alarm_active", 16'h0000, {14'h0000, alarm_active});
    smp(16'd190, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk16("alarm_active", 16'h0001, {14'h0000, alarm_active});
    smp(16'd190, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk16("alarm_active", 16'h0001, {14'h0000, alarm_active});
    smp(16'd190, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk16("alarm_active", 16'h0000, {14'h0000, alarm_active});
    // Alarm 2 on temperature: static above, then dynamic with count zero
    wr(OFF_ALM2_THRESH, 16'h0100);
    wr(OFF_ALARM_CTRL, 16'hc020);
    smp(16'd190, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk16("alarm_active", 16'h0002, {14'h0000, alarm_active});
    wr(OFF_ALARM_CTRL, 16'hc0a0);
    smp(16'd190, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk16("alarm_active", 16'h0000, {14'h0000, alarm_active});
    report_and_stop();
  end
endmodule // bias_trim_alarms_tb

// File: test/flash_partner.sv
// Flash backup responder that stands behind the bias trim block.
// Assumes flash_req is a one-cycle pulse on the same clock.
`timescale 1ns/10ps
module flash_partner #(
  parameter int DELAY = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Backup handshake
  input wire logic flash_req,
  output logic flash_done
);
  int cnt;
  logic busy;

  // Backup takes DELAY cycles, then one done pulse
  always @(posedge clk_sys) begin
    flash_done <= 1'b0;
    if (sys_rst) begin
      busy <= 1'b0;
      cnt <= 0;
    end else if (flash_req && !busy) begin
      busy <= 1'b1;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (cnt == DELAY - 1) begin
        busy <= 1'b0;
        flash_done <= 1'b1;
      end
    end
  end

  initial flash_done = 1'b0;
endmodule // flash_partner
